// file: bench/row_repair_assertions.sv
module row_repair_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic mr4_write,
   input wire logic [17:0] mr4_value,
   input wire logic repair_req,
   input wire row_repair_pkg::repair_op_type repair_op,
   input wire logic repair_done,
   input wire logic readout_req,
   input wire logic [1:0] readout_page,
   input wire logic [1:0] readout_loc,
   input wire logic readout_valid,
   input wire logic [7:0] readout_data
);
   import row_repair_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // Answers come exactly one cycle after the request
   a_repair_done_timing: assert property (repair_req |=> repair_done)
      else $error("repair answer missing");
   a_readout_valid_timing: assert property (readout_req |=> readout_valid)
      else $error("readout answer missing");
   a_done_one_cycle: assert property (repair_done |=> !repair_done)
      else $error("repair done held too long");
   // Constant readout contents
   a_limit_code_value: assert property (readout_req && readout_page == 2'h3 && readout_loc == 2'h3
      |=> readout_data[3:0] == 4'h8)
      else $error("activate limit code wrong");
   a_support_bits_set: assert property (readout_req && readout_page == 2'h2 && readout_loc == 2'h0
      |=> readout_data[7:6] == 2'b11)
      else $error("repair support bits wrong");
   // Data may only move with a fresh answer
   a_readout_data_holds: assert property (!readout_valid |-> $stable(readout_data))
      else $error("readout data changed without a read");
   // Both enables together would corrupt the repair row
   a_enables_exclusive: assert property (mr4_write |-> !(mr4_value[5] && mr4_value[13]))
      else $error("both repair enables set");
   a_soft_req_enabled: assert property (repair_req && repair_op == OP_SOFT_TYPE
      |-> $past(mr4_write) && $past(mr4_value[5]))
      else $error("soft repair without enable");
   a_hard_req_enabled: assert property (repair_req && repair_op inside {OP_HARD_WRA_TYPE,
      OP_HARD_WR_TYPE} |-> $past(mr4_write) && $past(mr4_value[13]))
      else $error("hard repair without enable");

   c_soft_repair: cover property (repair_req && repair_op == OP_SOFT_TYPE);
   c_hard_wra: cover property (repair_req && repair_op == OP_HARD_WRA_TYPE);
   c_limit_read: cover property (readout_req && readout_page == 2'h3);
endmodule

// file: bench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import row_repair_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, start = 1'b0, u_hard = 1'b0, u_wra = 1'b0;
   logic u_refresh = 1'b0, rd_start = 1'b0;
   logic [3:0] u_bank = 4'h0, lookup_bank = 4'h0;
   logic [16:0] u_row = 17'h00000;
   logic [1:0] u_page = 2'h0, u_loc = 2'h0;
   logic busy, last_acc, lookup_repaired, lookup_hard, lost, soft_en, hard_en;
   logic [7:0] last_rd;
   logic [16:0] lookup_row;
   logic [15:0] refresh_bank_en;
   logic [16:0] exp_row [16];
   logic exp_rep [16], exp_hard [16];
   logic [31:0] seed = 32'h5B3B;
   int fails = 0, samples_checked = 0;
   row_repair_if link();

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;

   row_repair_device u_row_repair_device (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
      .link(link), .lookup_bank(lookup_bank), .lookup_repaired(lookup_repaired),
      .lookup_hard(lookup_hard), .lookup_row(lookup_row), .refresh_bank_en(refresh_bank_en),
      .data_retention_lost(lost), .soft_enabled(soft_en), .hard_enabled(hard_en));
   row_repair_controller u_row_repair_controller (.core_clk(core_clk), .rst(rst),
      .clk_en(1'b1), .link(link), .user_repair_start(start), .user_hard(u_hard),
      .user_wra_form(u_wra), .user_bank(u_bank), .user_row(u_row), .user_refresh(u_refresh),
      .user_readout_start(rd_start), .user_page(u_page), .user_loc(u_loc), .busy(busy),
      .last_accepted(last_acc), .last_readout(last_rd));
   row_repair_assertions u_row_repair_assertions (.core_clk(core_clk), .rst(rst),
      .mr4_write(link.mr4_write), .mr4_value(link.mr4_value), .repair_req(link.repair_req),
      .repair_op(link.repair_op), .repair_done(link.repair_done),
      .readout_req(link.readout_req), .readout_page(link.readout_page),
      .readout_loc(link.readout_loc), .readout_valid(link.readout_valid),
      .readout_data(link.readout_data));

   function automatic logic [31:0] next_lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Fixed readout contents; upper nibble of the limit page reads zero
   function automatic logic [7:0] exp_read(input logic [1:0] p, input logic [1:0] l);
      if (p == 2'h3 && l == 2'h3) return 8'h08;
      if (p == 2'h2 && l == 2'h0) return 8'hC0;
      return 8'h00;
   endfunction
   // Refresh reach while a repair waits; bank pairs share the exclusion
   function automatic logic [15:0] exp_refresh(input logic hard, input logic write_autoprecharge_cmd,
         input logic [3:0] b);
      if (!hard) return 16'hFFFF;
      if (!write_autoprecharge_cmd) return 16'h0000;
      return ~(16'h0003 << {b[3:1], 1'b0});
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic read_loc(input logic [1:0] p, input logic [1:0] l);
      int i;
      @(posedge core_clk);
      rd_start <= 1'b1;
      u_page <= p;
      u_loc <= l;
      @(posedge core_clk);
      rd_start <= 1'b0;
      // Valid stands for one cycle only, so look right after the taking edge
      for (i = 0; i < 10; i++) begin
         #1;
         if (link.readout_valid === 1'b1) break;
         @(posedge core_clk);
      end
      check({i == 0, link.readout_data}, {1'b1, exp_read(p, l)});
      @(posedge core_clk);
      #1;
      check(last_rd, exp_read(p, l));
   endtask

   // A held hard row keeps its binding, whatever follows
   task automatic repair(input logic hard, input logic write_autoprecharge_cmd, input logic [3:0] b,
         input logic [16:0] r);
      int i;
      @(posedge core_clk);
      {u_hard, u_wra, u_bank, u_row, start} <= {hard, write_autoprecharge_cmd, b, r, 1'b1};
      u_refresh <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check(refresh_bank_en, exp_refresh(hard, write_autoprecharge_cmd, b));
      for (i = 0; i < 40 && busy !== 1'b0; i++) begin
         @(posedge core_clk);
         #1;
      end
      check(i, 2);
      check(last_acc, exp_hard[b] !== 1'b1);
      if (exp_hard[b] !== 1'b1) {exp_rep[b], exp_hard[b], exp_row[b]} = {1'b1, hard, r};
   endtask

   task automatic look_all();
      for (int b = 0; b < 16; b++) begin
         @(posedge core_clk);
         lookup_bank <= b[3:0];
         @(posedge core_clk);
         #1;
         check({lookup_repaired, lookup_hard, lookup_row},
            {exp_rep[b], exp_hard[b], exp_row[b]});
      end
   endtask

   initial begin
      logic [3:0] b;
      for (int k = 0; k < 16; k++) {exp_rep[k], exp_hard[k], exp_row[k]} = 19'h00000;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      for (int k = 0; k < 16; k++) read_loc(k[3:2], k[1:0]);
      // Random soft repairs; bank 3 and its alias stay free for the hard case
      for (int k = 0; k < 8; k++) begin
         seed = next_lfsr(seed);
         b = (seed[2:0] == 3'h3) ? seed[3:0] ^ 4'h1 : seed[3:0];
         repair(1'b0, 1'b0, b, seed[24:8]);
      end
      repair(1'b0, 1'b0, 4'h3, 17'h1FFFF);
      repair(1'b0, 1'b0, 4'h3, 17'h00001);
      repair(1'b1, 1'b1, 4'h3, 17'h0A5A5);
      repair(1'b0, 1'b0, 4'h3, 17'h12345);
      repair(1'b1, 1'b0, 4'h6, 17'h0F0F0);
      repair(1'b1, 1'b0, 4'h3, 17'h00000);
      look_all();
      check({soft_en, hard_en, lost}, 3'b001);
      for (int k = 0; k < 16; k++) read_loc(k[3:2], k[1:0]);
      wrap_up();
   end

   // Whole run needs a few hundred cycles
   initial begin
      #(25 * 20000);
      fails++;
      wrap_up();
   end
endmodule

// file: rtl/row_repair_controller.sv
module row_repair_controller (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   row_repair_if.controller link,
   input wire logic user_repair_start,
   input wire logic user_hard,
   input wire logic user_wra_form,
   input wire logic [row_repair_pkg::BANK_W-1:0] user_bank,
   input wire logic [row_repair_pkg::ROW_W-1:0] user_row,
   input wire logic user_refresh,
   input wire logic user_readout_start,
   input wire logic [1:0] user_page,
   input wire logic [1:0] user_loc,
   output logic busy,
   output logic last_accepted,
   output logic [7:0] last_readout
);
   import row_repair_pkg::*;

   typedef enum logic [2:0] {IDLE, ENABLE, REQ, WAIT, DISABLE} state_type;
   state_type state_q;
   logic hard_q;
   logic wra_q;
   logic [BANK_W-1:0] bank_q;
   logic [ROW_W-1:0] row_q;
   logic [7:0] held_hard_q;
   logic skip;

   // A request withheld from a hard-held bank must still close the sequence
   assign skip = hard_q && held_hard_q[bank_q[2:0]];

   // Sequence: enable one mode only, repair, then clear both enables
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= IDLE;
         hard_q <= 1'b0;
         wra_q <= 1'b0;
         bank_q <= '0;
         row_q <= '0;
      end else if (clk_en) begin
         case (state_q)
            IDLE: if (user_repair_start) begin
               hard_q <= user_hard;
               wra_q <= user_wra_form;
               bank_q <= user_bank;
               row_q <= user_row;
               state_q <= ENABLE;
            end
            ENABLE: state_q <= REQ;
            REQ: state_q <= WAIT;
            WAIT: if (link.repair_done || skip) begin
               state_q <= DISABLE;
            end
            DISABLE: state_q <= IDLE;
            default: state_q <= IDLE;
         endcase
      end
   end

   // Banks already hard repaired are skipped by keeping a small record
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         held_hard_q <= '0;
         last_accepted <= 1'b0;
      end else if (clk_en && state_q == WAIT && (link.repair_done || skip)) begin
         last_accepted <= link.repair_done && link.repair_accepted;
         if (hard_q && link.repair_accepted) begin
            held_hard_q[bank_q[2:0]] <= 1'b1;
         end
      end
   end

   always_comb begin
      link.mr4_write = clk_en && (state_q == ENABLE || state_q == DISABLE);
      link.mr4_value = '0; // Both enables cleared on exit
      if (state_q == ENABLE) begin
         link.mr4_value[MR4_HARD_EN_BIT] = hard_q; // Only one set
         link.mr4_value[MR4_SOFT_EN_BIT] = !hard_q;
      end
      link.repair_req = clk_en && state_q == REQ && !skip;
      link.repair_op = !hard_q ? OP_SOFT_TYPE :
         (wra_q ? OP_HARD_WRA_TYPE : OP_HARD_WR_TYPE);
      link.repair_bank = bank_q;
      link.repair_row = row_q;
      // No refresh in plain write hard form
      link.refresh_req = user_refresh && !(state_q != IDLE && hard_q && !wra_q);
      link.readout_req = clk_en && user_readout_start && state_q == IDLE;
      link.readout_page = user_page;
      link.readout_loc = user_loc;
   end
   assign busy = (state_q != IDLE);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last_readout <= '0;
      end else if (clk_en && link.readout_valid) begin
         last_readout <= link.readout_data;
      end
   end
endmodule

// file: rtl/row_repair_device.sv
// Overview of operation
// - Activate limit code sits in low nibble
// - Codes decode to fixed limits, others reserved
// - Background neighbour refresh, so report unlimited
// - Controller respects finite activate limits
// - Soft repair is volatile, may be reassigned
// - Hard repair binding is never released
// - No repeat hard repairs, never both enables
// - Controller supplies failing row address
// - Support bits 7 and 6 on page two
// - One repair row for every bank
// - Hard entry allowed with soft repairs held
// - Repairs in one bank spare other banks; controller skips hard requests to banks 8 apart from a hard-held bank
// - New soft repair replaces old soft address
// - Hard repair replaces soft and locks row
// - Held hard address never changes afterwards
// - Controller prepares banks and modes first; here it only writes the mode register four enable first
// - Mode register four bits enable repairs
// - Autoprecharge form keeps other banks refreshed; here the paired bank and, in the request cycle, all banks lose refresh
// - Plain write form allows no refresh
// - Controller sends guard keys in sequence; this controller sends no guard keys
module row_repair_device (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   row_repair_if.device link,
   input wire logic [row_repair_pkg::BANK_W-1:0] lookup_bank,
   output logic lookup_repaired,
   output logic lookup_hard,
   output logic [row_repair_pkg::ROW_W-1:0] lookup_row,
   output logic [row_repair_pkg::NUM_BANKS-1:0] refresh_bank_en,
   output logic data_retention_lost,
   output logic soft_enabled,
   output logic hard_enabled
);
   import row_repair_pkg::*;

   logic soft_en_q;
   logic hard_en_q;
   logic [NUM_BANKS-1:0] used_q;
   logic [NUM_BANKS-1:0] hard_q;
   logic [ROW_W-1:0] addr_q [NUM_BANKS];
   logic [BANK_W-1:0] busy_bank_q;
   logic busy_wra_q;
   logic lost_q;
   logic op_ok;
   logic [7:0] readout_d;

   // Enables follow mode register four writes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         soft_en_q <= 1'b0;
         hard_en_q <= 1'b0;
      end else if (clk_en && link.mr4_write) begin
         soft_en_q <= link.mr4_value[MR4_SOFT_EN_BIT];
         hard_en_q <= link.mr4_value[MR4_HARD_EN_BIT];
      end
   end
   assign soft_enabled = soft_en_q;
   assign hard_enabled = hard_en_q;

   // Operation must match the enabled mode; hard entry ignores held soft rows
   always_comb begin
      op_ok = 1'b0;
      case (link.repair_op)
         OP_SOFT_TYPE: op_ok = soft_en_q;
         OP_HARD_WRA_TYPE: op_ok = hard_en_q;
         OP_HARD_WR_TYPE: op_ok = hard_en_q;
         default: op_ok = 1'b0;
      endcase
   end

   // One repair row per bank, each bank updated only by its own request
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         logic hit;
         assign hit = clk_en && link.repair_req && op_ok &&
            (link.repair_bank == BANK_W'(b));
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               used_q[b] <= 1'b0; // Soft content lost at reset
               addr_q[b] <= '0;
            end else if (hit && !hard_q[b]) begin
               used_q[b] <= 1'b1;
               addr_q[b] <= link.repair_row;
            end
         end
         // Reset here clears hard state too in sim, though only soft state is lost at power cycle
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               hard_q[b] <= 1'b0;
            end else if (hit && link.repair_op != OP_SOFT_TYPE) begin
               hard_q[b] <= 1'b1; // Never cleared after set
            end
         end
      end
   endgenerate

   // Remember bank under hard repair and which form is running
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_bank_q <= '0;
         busy_wra_q <= 1'b0;
         lost_q <= 1'b0;
      end else if (clk_en) begin
         if (link.repair_req && op_ok && link.repair_op != OP_SOFT_TYPE) begin
            busy_bank_q <= link.repair_bank;
            busy_wra_q <= (link.repair_op == OP_HARD_WRA_TYPE);
            lost_q <= (link.repair_op == OP_HARD_WR_TYPE);
         end else if (link.mr4_write && !link.mr4_value[MR4_HARD_EN_BIT]) begin
            busy_wra_q <= 1'b0;
         end
      end
   end
   assign data_retention_lost = lost_q;

   // Refresh reaches all banks except the one under autoprecharge repair, bit zero ignored; no bank in plain write form
   always_comb begin
      for (int i = 0; i < NUM_BANKS; i++) begin
         refresh_bank_en[i] = link.refresh_req;
         if (hard_en_q && !busy_wra_q) begin
            refresh_bank_en[i] = 1'b0;
         end else if (hard_en_q && busy_wra_q &&
            (BANK_W'(i) >> 1) == (busy_bank_q >> 1)) begin
            refresh_bank_en[i] = 1'b0;
         end
      end
   end

   // Repair answer one cycle after request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link.repair_done <= 1'b0;
         link.repair_accepted <= 1'b0;
      end else if (clk_en) begin
         link.repair_done <= link.repair_req;
         link.repair_accepted <= link.repair_req && op_ok &&
            !hard_q[link.repair_bank];
      end
   end

   // Readout contents are constants; no path writes them
   always_comb begin
      readout_d = READOUT_UPPER_RESET;
      if (link.readout_page == READOUT_PAGE3 && link.readout_loc == READOUT_LOC3) begin
         readout_d[ACT_LIMIT_LSB +: 4] = ACT_LIMIT_UNLIMITED;
      end else if (link.readout_page == READOUT_PAGE2 &&
         link.readout_loc == READOUT_LOC0) begin
         readout_d[HARD_SUPPORT_BIT] = 1'b1;
         readout_d[SOFT_SUPPORT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link.readout_valid <= 1'b0;
         link.readout_data <= '0;
      end else if (clk_en) begin
         link.readout_valid <= link.readout_req;
         if (link.readout_req) begin
            link.readout_data <= readout_d;
         end
      end
   end

   // Lookup port shows per bank repair state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lookup_repaired <= 1'b0;
         lookup_hard <= 1'b0;
         lookup_row <= '0;
      end else if (clk_en) begin
         lookup_repaired <= used_q[lookup_bank];
         lookup_hard <= hard_q[lookup_bank];
         lookup_row <= addr_q[lookup_bank];
      end
   end
endmodule

// file: rtl/row_repair_if.sv
interface row_repair_if;
   import row_repair_pkg::*;
   logic mr4_write;
   logic [17:0] mr4_value;
   logic repair_req;
   repair_op_type repair_op;
   logic [row_repair_pkg::BANK_W-1:0] repair_bank;
   logic [row_repair_pkg::ROW_W-1:0] repair_row;
   logic repair_done;
   logic repair_accepted;
   logic readout_req;
   logic [1:0] readout_page;
   logic [1:0] readout_loc;
   logic readout_valid;
   logic [7:0] readout_data;
   logic refresh_req;
   modport controller(output mr4_write, mr4_value, repair_req, repair_op, repair_bank,
      repair_row, readout_req, readout_page, readout_loc, refresh_req,
      input repair_done, repair_accepted, readout_valid, readout_data);
   modport device(input mr4_write, mr4_value, repair_req, repair_op, repair_bank,
      repair_row, readout_req, readout_page, readout_loc, refresh_req,
      output repair_done, repair_accepted, readout_valid, readout_data);
endinterface

// file: rtl/row_repair_pkg.sv
package row_repair_pkg;
   localparam int NUM_BANKS = 16;
   localparam int BANK_W = 4;
   localparam int ROW_W = 17;
   localparam logic [3:0] ACT_LIMIT_UNLIMITED = 4'h8;
   localparam logic [3:0] ACT_LIMIT_UNTESTED = 4'h0;
   localparam logic [3:0] ACT_LIMIT_700K = 4'h1;
   localparam logic [3:0] ACT_LIMIT_600K = 4'h2;
   localparam logic [3:0] ACT_LIMIT_500K = 4'h3;
   localparam logic [3:0] ACT_LIMIT_400K = 4'h4;
   localparam logic [3:0] ACT_LIMIT_300K = 4'h5;
   localparam logic [3:0] ACT_LIMIT_200K = 4'h7;
   localparam int ACT_LIMIT_LSB = 0;
   localparam int HARD_SUPPORT_BIT = 7;
   localparam int SOFT_SUPPORT_BIT = 6;
   localparam int MR4_SOFT_EN_BIT = 5;
   localparam int MR4_HARD_EN_BIT = 13;
   localparam logic [1:0] READOUT_PAGE2 = 2'h2;
   localparam logic [1:0] READOUT_PAGE3 = 2'h3;
   localparam logic [1:0] READOUT_LOC0 = 2'h0;
   localparam logic [1:0] READOUT_LOC3 = 2'h3;
   localparam logic [7:0] READOUT_UPPER_RESET = 8'h00;
   typedef enum logic [1:0] {
      OP_NONE_TYPE, OP_SOFT_TYPE, OP_HARD_WRA_TYPE, OP_HARD_WR_TYPE
   } repair_op_type;
endpackage
